// File: verilog/pit_pkg.sv
`default_nettype none
package pit_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned COUNT_W = 16;
    localparam int unsigned SCALE_W = 8;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_COUNT  = 8'h00;
    localparam logic [7:0] OFF_SCALE  = 8'h04;
    localparam logic [7:0] OFF_PERIOD = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_MASK   = 8'h10;
    localparam logic [7:0] OFF_CTRL   = 8'h14;
    localparam logic [7:0] OFF_VECTOR = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned STAT_ZERO_BIT  = 0;

    // ------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------
    localparam logic [15:0] COUNT_RST  = 16'h0000;
    localparam logic [7:0]  SCALE_RST  = 8'h00;
    localparam logic [15:0] PERIOD_RST = 16'h0000;
    localparam logic        MASK_RST   = 1'h0;
    localparam logic        RUN_RST    = 1'h0;
    localparam logic [15:0] IRQ_VECTOR = 16'h0028;
    localparam logic [3:0]  IRQ_LEVEL  = 4'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       run;
        logic [7:0] scale;
    } pit_presc_cfg_type;

endpackage
`default_nettype wire

// File: verilog/pit_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module pit_prescaler (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire pit_pkg::pit_presc_cfg_type cfg,
    output logic                            tick
);

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // ------------------------------------------------------------
    // One pulse per scale cycles, zero or one gives every cycle
    // ------------------------------------------------------------
    always_comb begin
        tick  = cfg.run && ((cfg.scale <= 8'h01) || (cnt_q >= cfg.scale - 8'h01));
        cnt_d = cnt_q;
        if (!cfg.run || tick) begin
            cnt_d = 8'h00;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule
`default_nettype wire

// File: verilog/pit_timer.sv
// Notes on behaviour
// - Keep a 16-bit down-counter, software accessible, decremented per prescaled interval.
// - Cycles between decrements come from an 8-bit software scaling register.
// - Counter at zero raises the timer interrupt, giving a regular period.
// - On that zero event, reload the counter from the 16-bit period register.
// - Interrupt is lowest priority, vector 0028 hex, individually maskable.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pit_timer (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic [15:0]      irq_vector,
    output logic [3:0]       irq_level
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [7:0]  scale_q;
    logic [7:0]  scale_d;
    logic [15:0] period_q;
    logic [15:0] period_d;
    logic        status_q;
    logic        status_d;
    logic        mask_q;
    logic        mask_d;
    logic        run_q;
    logic        run_d;
    logic        irq_q;
    logic        irq_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic        tick;
    logic        zero_evt;
    logic        acc;
    logic        wr_acc;
    logic        mapped;
    pit_pkg::pit_presc_cfg_type presc_cfg;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    assign presc_cfg.run   = run_q;
    assign presc_cfg.scale = scale_q;

    pit_prescaler u_presc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cfg     (presc_cfg),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    assign acc    = psel && penable && pready_q;
    assign wr_acc = acc && pwrite;
    assign mapped = hit(paddr, pit_pkg::OFF_COUNT) || hit(paddr, pit_pkg::OFF_SCALE)
                 || hit(paddr, pit_pkg::OFF_PERIOD) || hit(paddr, pit_pkg::OFF_STATUS)
                 || hit(paddr, pit_pkg::OFF_MASK) || hit(paddr, pit_pkg::OFF_CTRL)
                 || hit(paddr, pit_pkg::OFF_VECTOR);

    always_comb begin
        pready_d  = psel && penable && !pready_q;
        pslverr_d = 1'b0;
        prdata_d  = 32'h0000_0000;
        if (pready_d) begin
            pslverr_d = !mapped;
            if (!pwrite) begin
                unique case (1'b1)
                    hit(paddr, pit_pkg::OFF_COUNT):  prdata_d = {16'h0000, count_q};
                    hit(paddr, pit_pkg::OFF_SCALE):  prdata_d = {24'h00_0000, scale_q};
                    hit(paddr, pit_pkg::OFF_PERIOD): prdata_d = {16'h0000, period_q};
                    hit(paddr, pit_pkg::OFF_STATUS): prdata_d = {31'h0000_0000, status_q};
                    hit(paddr, pit_pkg::OFF_MASK):   prdata_d = {31'h0000_0000, mask_q};
                    hit(paddr, pit_pkg::OFF_CTRL):   prdata_d = {31'h0000_0000, run_q};
                    hit(paddr, pit_pkg::OFF_VECTOR): prdata_d = {16'h0000, pit_pkg::IRQ_VECTOR};
                    default:                         prdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_comb begin
        scale_d  = scale_q;
        period_d = period_q;
        mask_d   = mask_q;
        run_d    = run_q;
        if (wr_acc && hit(paddr, pit_pkg::OFF_SCALE)) begin
            scale_d = pwdata[7:0];
        end
        if (wr_acc && hit(paddr, pit_pkg::OFF_PERIOD)) begin
            period_d = pwdata[15:0];
        end
        if (wr_acc && hit(paddr, pit_pkg::OFF_MASK)) begin
            mask_d = pwdata[pit_pkg::STAT_ZERO_BIT];
        end
        if (wr_acc && hit(paddr, pit_pkg::OFF_CTRL)) begin
            run_d = pwdata[pit_pkg::CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scale_q  <= pit_pkg::SCALE_RST;
            period_q <= pit_pkg::PERIOD_RST;
            mask_q   <= pit_pkg::MASK_RST;
            run_q    <= pit_pkg::RUN_RST;
        end else begin
            scale_q  <= scale_d;
            period_q <= period_d;
            mask_q   <= mask_d;
            run_q    <= run_d;
        end
    end

    // ------------------------------------------------------------
    // Down-counter, zero event and interrupt
    // ------------------------------------------------------------
    assign zero_evt = tick && (count_q == 16'h0000);

    always_comb begin
        count_d = count_q;
        if (wr_acc && hit(paddr, pit_pkg::OFF_COUNT)) begin
            count_d = pwdata[15:0];
        end else if (zero_evt) begin
            count_d = period_q;
        end else if (tick) begin
            count_d = count_q - 16'h0001;
        end
        status_d = status_q;
        if (wr_acc && hit(paddr, pit_pkg::OFF_STATUS) && pwdata[pit_pkg::STAT_ZERO_BIT]) begin
            status_d = 1'b0;
        end
        if (zero_evt) begin
            status_d = 1'b1;
        end
        irq_d = status_q && mask_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q  <= pit_pkg::COUNT_RST;
            status_q <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            count_q  <= count_d;
            status_q <= status_d;
            irq_q    <= irq_d;
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign irq        = irq_q;
    assign irq_vector = pit_pkg::IRQ_VECTOR;
    assign irq_level  = pit_pkg::IRQ_LEVEL;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic cnt_wr;
    assign cnt_wr = wr_acc && hit(paddr, pit_pkg::OFF_COUNT);

    property p_decrement;
        (tick && count_q != 16'h0000 && !cnt_wr) |=> (count_q == $past(count_q) - 16'h0001);
    endproperty
    a_decrement: assert property (p_decrement) else $error("Counter did not decrement on tick");

    property p_hold;
        (!tick && !cnt_wr) |=> $stable(count_q);
    endproperty
    a_hold: assert property (p_hold) else $error("Counter changed without tick");

    property p_scale_gap;
        (tick && scale_q == 8'h03 && run_q) ##1 (scale_q == 8'h03 && run_q)[*2] |-> !$past(tick) && !tick;
    endproperty
    a_scale_gap: assert property (p_scale_gap) else $error("Prescale pulse too early");

    property p_scale_next;
        (tick && scale_q == 8'h03) ##1 (scale_q == 8'h03 && run_q)[*3] |-> tick;
    endproperty
    a_scale_next: assert property (p_scale_next) else $error("Prescale pulse missing");

    property p_scale_zero;
        (run_q && scale_q == 8'h00) |-> tick;
    endproperty
    a_scale_zero: assert property (p_scale_zero) else $error("Scale zero must tick every cycle");

    property p_status_set;
        zero_evt |=> status_q ##1 (irq_q == mask_q || !$stable(mask_q));
    endproperty
    a_status_set: assert property (p_status_set) else $error("Zero event lost");

    property p_reload;
        (zero_evt && !cnt_wr) |=> (count_q == $past(period_q));
    endproperty
    a_reload: assert property (p_reload) else $error("Counter not reloaded");

    property p_irq_mask;
        (status_q && mask_q) |=> irq_q;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("Unmasked interrupt not raised");

    property p_irq_quiet;
        !(status_q && mask_q) |=> !irq_q;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("Interrupt raised while masked");

    c_zero_evt:   cover property (zero_evt);
    c_irq:        cover property (!irq_q ##1 irq_q);
    c_reload_clr: cover property (zero_evt ##[1:20] (wr_acc && hit(paddr, pit_pkg::OFF_STATUS)));

endmodule
`default_nettype wire

// File: dv/pit_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pit_timer_bench;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [15:0] irq_vector;
    logic [3:0]  irq_level;
    logic [31:0] rd;
    logic        er;
    logic [31:0] lfsr      = 32'h0001_7dfb;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cyc       = 0;
    int          last_rise = 0;
    int          prev_rise = 0;
    int          rise_cnt  = 0;
    int          c;
    int          p;
    logic        irq_d     = 1'b0;

    pit_timer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .irq_vector(irq_vector), .irq_level(irq_level));

    always #20 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Interrupt edge timing
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc   <= cyc + 1;
        irq_d <= irq;
        if (irq === 1'b1 && irq_d === 1'b0) begin
            prev_rise <= last_rise;
            last_rise <= cyc;
            rise_cnt  <= rise_cnt + 1;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic int interval(input int per, input int scl);
        return (per + 1) * ((scl < 1) ? 1 : scl);
    endfunction

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            give_verdict();
        end
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq !== lvl && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        check(irq, lvl);
        if (irq !== lvl) begin
            give_verdict();
        end
    endtask

    task automatic wait_rise();
        int n;
        n = 0;
        while (rise_cnt == c && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 300) begin
            error_cnt++;
            give_verdict();
        end
        c = rise_cnt;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        check(irq_vector, 32'h0000_0028);
        check(irq_level, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check(rd, (i == 6) ? 32'h0000_0028 : 32'h0);
        end
        for (int i = 0; i < 6; i++) begin
            lfsr = next_rand(lfsr);
            apb(1'b1, 8'(4 * (i % 3)), lfsr);
            apb(1'b0, 8'(4 * (i % 3)), 32'h0);
            check(rd, lfsr & ((i % 3 == 1) ? 32'h0000_00ff : 32'h0000_ffff));
            check(er, 1'b0);
        end
        apb(1'b1, pit_pkg::OFF_VECTOR, 32'h0000_ffff);
        apb(1'b0, pit_pkg::OFF_VECTOR, 32'h0);
        check(rd, 32'h0000_0028);
        apb(1'b1, 8'h1c, 32'hffff_ffff);
        check(er, 1'b1);
        apb(1'b0, 8'hfc, 32'h0);
        check(er, 1'b1);
        check(rd, 32'h0);
        // Masked event stays off the line until unmasked
        apb(1'b1, pit_pkg::OFF_SCALE, 32'h0);
        apb(1'b1, pit_pkg::OFF_PERIOD, 32'h3);
        apb(1'b1, pit_pkg::OFF_COUNT, 32'h0);
        apb(1'b1, pit_pkg::OFF_CTRL, 32'h1);
        rd = 32'h0;
        for (int n = 0; n < 20 && rd[0] !== 1'b1; n++) begin
            apb(1'b0, pit_pkg::OFF_STATUS, 32'h0);
        end
        check(rd, 32'h1);
        if (rd !== 32'h1) begin
            give_verdict();
        end
        check(irq, 1'b0);
        apb(1'b1, pit_pkg::OFF_MASK, 32'h1);
        wait_irq(1'b1);
        apb(1'b1, pit_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, pit_pkg::OFF_STATUS, 32'h1);
        wait_irq(1'b0);
        // Interrupt period for each prescale corner
        for (int s = 0; s < 5; s++) begin
            lfsr = next_rand(lfsr);
            p = 8 + int'(lfsr[2:0]);
            apb(1'b1, pit_pkg::OFF_SCALE, 32'(s));
            apb(1'b1, pit_pkg::OFF_PERIOD, 32'(p));
            apb(1'b1, pit_pkg::OFF_COUNT, 32'h0);
            c = rise_cnt;
            apb(1'b1, pit_pkg::OFF_CTRL, 32'h1);
            wait_rise();
            apb(1'b1, pit_pkg::OFF_STATUS, 32'h1);
            wait_irq(1'b0);
            wait_rise();
            check(32'(last_rise - prev_rise), 32'(interval(p, s)));
            apb(1'b1, pit_pkg::OFF_CTRL, 32'h0);
            apb(1'b1, pit_pkg::OFF_STATUS, 32'h1);
            wait_irq(1'b0);
        end
        // Reload value seen after an event with a long period
        apb(1'b1, pit_pkg::OFF_PERIOD, 32'h0000_8000);
        apb(1'b1, pit_pkg::OFF_SCALE, 32'h0000_00ff);
        apb(1'b1, pit_pkg::OFF_COUNT, 32'h0);
        c = rise_cnt;
        apb(1'b1, pit_pkg::OFF_CTRL, 32'h1);
        wait_rise();
        apb(1'b0, pit_pkg::OFF_COUNT, 32'h0);
        check(rd, 32'h0000_8000);
        give_verdict();
    end
endmodule
`default_nettype wire
